// File: sstf_codec.sv
`default_nettype none

module sstf_codec (
  input wire logic run,
  input wire logic data_line,
  input wire logic sync_line,
  output logic link_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bq[$];
  logic fq[$];
  // link clock runs only while a frame is wanted, rests high
  initial begin
    link_clk = 1'b1;
    forever begin
      #100;
      if (run || !link_clk) begin
        link_clk = ~link_clk;
      end
    end
  end
  // bits shift on the falling edge, so sample on the rising edge
  always @(posedge link_clk) begin
    bq.push_back(data_line);
    fq.push_back(sync_line);
  end
endmodule

`default_nettype wire

// File: sstf_pkg.sv
// How it works
// - each data word is sent as word bit count plus one bits
// - dma size is byte up to 7, half-word to 15, else word
// - the data pin rests at the idle line level outside transmission
// - with multi-drive set, the data pin driver is on only for a one
// - high bit first clear sends lsb first, set sends msb first
// - each transfer start sends words per frame plus one words
// - frame sync lasts sync pulse length plus one link clock periods
// - with sync data output on, that many sync bits are shifted out
// - sync output shape selects none, pulses, levels or toggle; 6-7 reserved
// - during frame sync the data pin carries idle level or sync bits
// - tx sync event is set on rising or falling frame sync edge
// - data words sit right aligned in their 32-bit holding registers
// - tx sync holding keeps 16 writable sync bits in bits 15 to 0
// - rx sync holding shows rx sync length plus one read-only sampled sync bits, upper bits zero
// - rx compare zero keeps a 16-bit writable pattern
// - the received sync sequence is compared against pattern zero or one
// - rx sync length plus one sets how many sync bits are kept
`default_nettype none

package sstf_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_FRAME_MODE = 8'h00;
  localparam logic [7:0] OFS_RX_HOLD = 8'h04;
  localparam logic [7:0] OFS_TX_HOLD = 8'h08;
  localparam logic [7:0] OFS_RX_SYNC = 8'h0c;
  localparam logic [7:0] OFS_TX_SYNC = 8'h10;
  localparam logic [7:0] OFS_CMP_ZERO = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // ----------------------------------------
  // tx_frame_mode fields
  // ----------------------------------------
  localparam int LEN_LSB = 0;
  localparam int LEN_MSB = 4;
  localparam int IDLE_BIT = 5;
  localparam int HIGH_BIT_FIRST_BIT = 7;
  localparam int NB_LSB = 8;
  localparam int NB_MSB = 11;
  localparam int SYNC_PULSE_LENGTH_LSB = 16;
  localparam int SYNC_PULSE_LENGTH_MSB = 19;
  localparam int SYNC_OUTPUT_SHAPE_LSB = 20;
  localparam int SYNC_OUTPUT_SHAPE_MSB = 22;
  localparam int SYNC_DATA_OUTPUT_ENABLE_BIT = 23;
  localparam int EDGE_BIT = 24;
  localparam logic [31:0] FRAME_MODE_MASK = 32'h01ff0fbf;
  localparam logic [31:0] FRAME_MODE_RESET = 32'h00000000;

  // control and status bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_MULTI = 1;
  localparam int ST_SYNC_EVT = 0;
  localparam int ST_HOLD_EMPTY = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_RX_READY = 3;
  localparam int ST_CMP_MATCH = 4;

  // ----------------------------------------
  // sync output shape codes
  // ----------------------------------------
  localparam logic [2:0] FS_NONE = 3'h0;
  localparam logic [2:0] FS_NEG_PULSE = 3'h1;
  localparam logic [2:0] FS_POS_PULSE = 3'h2;
  localparam logic [2:0] FS_LOW_XFER = 3'h3;
  localparam logic [2:0] FS_HIGH_XFER = 3'h4;
  localparam logic [2:0] FS_TOGGLE = 3'h5;

  // dma transfer size codes and their length limits
  localparam logic [1:0] DMA_BYTE = 2'h0;
  localparam logic [1:0] DMA_HALF = 2'h1;
  localparam logic [1:0] DMA_WORD = 2'h2;
  localparam logic [4:0] LEN_BYTE_MAX = 5'h07;
  localparam logic [4:0] LEN_HALF_MAX = 5'h0f;

  typedef enum logic [1:0] {SSTF_IDLE, SSTF_SYNC, SSTF_DATA} sstf_state_t;
endpackage

// ----------------------------------------
// two flip-flop synchroniser
// ----------------------------------------
module sstf_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

`default_nettype wire

// File: sstf_tx.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`default_nettype none

module sstf_tx (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tx_clk_pin,
  input wire logic tx_start,
  output logic tx_data_pin_o,
  output logic tx_data_pin_oe,
  input wire logic tx_frame_sync_pin_i,
  output logic tx_frame_sync_pin_o,
  output logic tx_frame_sync_pin_oe,
  output logic tx_sync_event,
  output logic [1:0] dma_size,
  output logic dma_req,
  input wire logic rx_word_valid,
  input wire logic [31:0] rx_word,
  input wire logic rx_sync_load,
  input wire logic [15:0] rx_sync_bits,
  input wire logic [3:0] rx_sync_length,
  input wire logic compare_select_one,
  input wire logic [15:0] compare_pattern_one,
  output logic [15:0] compare_pattern_zero,
  output logic rx_sync_match
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [31:0] frame_mode;
  logic [31:0] tx_holding;
  logic [31:0] rx_holding;
  logic holding_full;
  logic rx_ready;
  logic [15:0] tx_sync_bits;
  logic [15:0] rx_sync_hold;
  logic tx_enable;
  logic multi_drive;
  logic sync_evt_flag;
  logic start_pending;
  logic [1:0] pin_sync;
  logic clk_prev;
  logic tick;
  sstf_pkg::sstf_state_t state;
  logic [4:0] bit_cnt;
  logic [3:0] word_cnt;
  logic [3:0] sync_cnt;
  logic [31:0] shift_word;
  logic fs_toggle;
  logic fs_level_prev;
  logic [4:0] word_bit_count;
  logic idle_line_level;
  logic high_bit_first;
  logic [3:0] words_per_frame;
  logic [3:0] sync_pulse_length;
  logic [2:0] sync_output_shape;
  logic sync_data_output_enable;
  logic sync_edge_select;
  logic has_sync_phase;
  logic last_bit;
  logic last_sync;
  logic take_word;
  logic [4:0] data_idx;
  logic [3:0] sync_idx;
  logic next_line;
  logic next_fs;
  logic next_fs_oe;
  logic fs_level;
  logic sync_edge;
  logic status_read;
  logic rx_read;
  logic [15:0] cmp_mask;
  logic [15:0] cmp_pattern;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign word_bit_count = frame_mode[sstf_pkg::LEN_MSB:sstf_pkg::LEN_LSB];
  assign idle_line_level = frame_mode[sstf_pkg::IDLE_BIT];
  assign high_bit_first = frame_mode[sstf_pkg::HIGH_BIT_FIRST_BIT];
  assign words_per_frame = frame_mode[sstf_pkg::NB_MSB:sstf_pkg::NB_LSB];
  assign sync_pulse_length = frame_mode[sstf_pkg::SYNC_PULSE_LENGTH_MSB:sstf_pkg::SYNC_PULSE_LENGTH_LSB];
  assign sync_output_shape = frame_mode[sstf_pkg::SYNC_OUTPUT_SHAPE_MSB:sstf_pkg::SYNC_OUTPUT_SHAPE_LSB];
  assign sync_data_output_enable = frame_mode[sstf_pkg::SYNC_DATA_OUTPUT_ENABLE_BIT];
  assign sync_edge_select = frame_mode[sstf_pkg::EDGE_BIT];
  assign status_read = reg_rd && (reg_addr == sstf_pkg::OFS_STATUS);
  assign rx_read = reg_rd && (reg_addr == sstf_pkg::OFS_RX_HOLD);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_mode <= sstf_pkg::FRAME_MODE_RESET;
      tx_sync_bits <= 16'h0000;
      compare_pattern_zero <= 16'h0000;
      tx_enable <= 1'b0;
      multi_drive <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        sstf_pkg::OFS_FRAME_MODE: frame_mode <= reg_wdata & sstf_pkg::FRAME_MODE_MASK;
        sstf_pkg::OFS_TX_SYNC: tx_sync_bits <= reg_wdata[15:0];
        sstf_pkg::OFS_CMP_ZERO: compare_pattern_zero <= reg_wdata[15:0];
        sstf_pkg::OFS_CONTROL: begin
          tx_enable <= reg_wdata[sstf_pkg::CTL_ENABLE];
          multi_drive <= reg_wdata[sstf_pkg::CTL_MULTI];
        end
        default: ;
      endcase
    end
  end

  // transmit holding, right aligned; a write wins over the engine taking it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding <= 32'h00000000;
      holding_full <= 1'b0;
    end else if (reg_wr && (reg_addr == sstf_pkg::OFS_TX_HOLD)) begin
      tx_holding <= reg_wdata;
      holding_full <= 1'b1;
    end else if (take_word) begin
      holding_full <= 1'b0;
    end
  end

  // receive holding and ready flag; a new word wins over the read clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding <= 32'h00000000;
      rx_ready <= 1'b0;
    end else if (rx_word_valid) begin
      rx_holding <= rx_word;
      rx_ready <= 1'b1;
    end else if (rx_read) begin
      rx_ready <= 1'b0;
    end
  end

  // ----------------------------------------
  // receive sync holding and compare
  // ----------------------------------------
  // mask keeps rx sync length plus one low bits
  assign cmp_mask = 16'hffff >> (4'hf - rx_sync_length);
  assign cmp_pattern = compare_select_one ? compare_pattern_one : compare_pattern_zero;

  // capture sampled sync bits and compare them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_hold <= 16'h0000;
      rx_sync_match <= 1'b0;
    end else if (rx_sync_load) begin
      rx_sync_hold <= rx_sync_bits & cmp_mask;
      rx_sync_match <= ((rx_sync_bits ^ cmp_pattern) & cmp_mask) == 16'h0000;
    end
  end

  // ----------------------------------------
  // link clock and frame sync pin sampling
  // ----------------------------------------
  sstf_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({tx_frame_sync_pin_i, tx_clk_pin}),
    .q(pin_sync)
  );

  // shift on the falling edge of the link clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= pin_sync[0];
    end
  end
  assign tick = clk_prev && !pin_sync[0];

  // ----------------------------------------
  // transmit sequencer
  // ----------------------------------------
  assign has_sync_phase = (sync_output_shape == sstf_pkg::FS_NEG_PULSE) ||
                          (sync_output_shape == sstf_pkg::FS_POS_PULSE) ||
                          sync_data_output_enable;
  assign last_bit = (bit_cnt == word_bit_count);
  assign last_sync = (sync_cnt == sync_pulse_length);
  assign take_word = tick && (((state == sstf_pkg::SSTF_IDLE) && start_pending &&
                               holding_full) ||
                              ((state == sstf_pkg::SSTF_DATA) && last_bit &&
                               (word_cnt != words_per_frame)));

  // start request is held until taken; a new start wins over the take
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_pending <= 1'b0;
    end else if (tx_start && tx_enable) begin
      start_pending <= 1'b1;
    end else if (take_word && (state == sstf_pkg::SSTF_IDLE)) begin
      start_pending <= 1'b0;
    end
  end

  // frame state, counters and shift word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= sstf_pkg::SSTF_IDLE;
      bit_cnt <= 5'h00;
      word_cnt <= 4'h0;
      sync_cnt <= 4'h0;
      shift_word <= 32'h00000000;
      fs_toggle <= 1'b0;
    end else if (tick) begin
      case (state)
        sstf_pkg::SSTF_IDLE: begin
          bit_cnt <= 5'h00;
          word_cnt <= 4'h0;
          sync_cnt <= 4'h0;
          if (take_word) begin
            shift_word <= tx_holding;
            if (sync_output_shape == sstf_pkg::FS_TOGGLE) begin
              fs_toggle <= !fs_toggle;
            end
            state <= has_sync_phase ? sstf_pkg::SSTF_SYNC : sstf_pkg::SSTF_DATA;
          end
        end
        sstf_pkg::SSTF_SYNC: begin
          sync_cnt <= sync_cnt + 4'h1;
          if (last_sync) begin
            state <= sstf_pkg::SSTF_DATA;
          end
        end
        sstf_pkg::SSTF_DATA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (last_bit) begin
            bit_cnt <= 5'h00;
            word_cnt <= word_cnt + 4'h1;
            if (word_cnt == words_per_frame) begin
              state <= sstf_pkg::SSTF_IDLE;
            end else begin
              shift_word <= tx_holding;
            end
          end
        end
        default: state <= sstf_pkg::SSTF_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // line levels
  // ----------------------------------------
  assign data_idx = high_bit_first ? (word_bit_count - bit_cnt) : bit_cnt;
  assign sync_idx = high_bit_first ? (sync_pulse_length - sync_cnt) : sync_cnt;

  // data line for the present phase
  always_comb begin
    case (state)
      sstf_pkg::SSTF_SYNC: begin
        next_line = sync_data_output_enable ? tx_sync_bits[sync_idx] : idle_line_level;
      end
      sstf_pkg::SSTF_DATA: next_line = shift_word[data_idx];
      default: next_line = idle_line_level;
    endcase
  end

  // frame sync level per output shape
  always_comb begin
    next_fs_oe = 1'b1;
    case (sync_output_shape)
      sstf_pkg::FS_NEG_PULSE: next_fs = state != sstf_pkg::SSTF_SYNC;
      sstf_pkg::FS_POS_PULSE: next_fs = state == sstf_pkg::SSTF_SYNC;
      sstf_pkg::FS_LOW_XFER: next_fs = state != sstf_pkg::SSTF_DATA;
      sstf_pkg::FS_HIGH_XFER: next_fs = state == sstf_pkg::SSTF_DATA;
      sstf_pkg::FS_TOGGLE: next_fs = fs_toggle;
      default: begin
        next_fs = 1'b0;
        next_fs_oe = 1'b0;
      end
    endcase
  end

  // pin registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_pin_o <= 1'b0;
      tx_data_pin_oe <= 1'b0;
      tx_frame_sync_pin_o <= 1'b0;
      tx_frame_sync_pin_oe <= 1'b0;
    end else begin
      tx_data_pin_o <= next_line;
      tx_data_pin_oe <= multi_drive ? next_line : 1'b1;
      tx_frame_sync_pin_o <= next_fs;
      tx_frame_sync_pin_oe <= next_fs_oe;
    end
  end

  // ----------------------------------------
  // sync edge event
  // ----------------------------------------
  assign fs_level = tx_frame_sync_pin_oe ? tx_frame_sync_pin_o : pin_sync[1];
  assign sync_edge = sync_edge_select ? (fs_level_prev && !fs_level) :
                                        (!fs_level_prev && fs_level);

  // sticky event, cleared by a status read; a new edge wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fs_level_prev <= 1'b0;
      sync_evt_flag <= 1'b0;
    end else begin
      fs_level_prev <= fs_level;
      if (sync_edge) begin
        sync_evt_flag <= 1'b1;
      end else if (status_read) begin
        sync_evt_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // dma outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma_size <= sstf_pkg::DMA_BYTE;
      dma_req <= 1'b0;
      tx_sync_event <= 1'b0;
    end else begin
      if (word_bit_count <= sstf_pkg::LEN_BYTE_MAX) begin
        dma_size <= sstf_pkg::DMA_BYTE;
      end else if (word_bit_count <= sstf_pkg::LEN_HALF_MAX) begin
        dma_size <= sstf_pkg::DMA_HALF;
      end else begin
        dma_size <= sstf_pkg::DMA_WORD;
      end
      dma_req <= tx_enable && !holding_full && !take_word;
      tx_sync_event <= sync_evt_flag;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      sstf_pkg::OFS_FRAME_MODE: next_rdata = frame_mode;
      sstf_pkg::OFS_RX_HOLD: next_rdata = rx_holding;
      sstf_pkg::OFS_RX_SYNC: next_rdata = {16'h0000, rx_sync_hold};
      sstf_pkg::OFS_TX_SYNC: next_rdata = {16'h0000, tx_sync_bits};
      sstf_pkg::OFS_CMP_ZERO: next_rdata = {16'h0000, compare_pattern_zero};
      sstf_pkg::OFS_CONTROL: begin
        next_rdata[sstf_pkg::CTL_ENABLE] = tx_enable;
        next_rdata[sstf_pkg::CTL_MULTI] = multi_drive;
      end
      sstf_pkg::OFS_STATUS: begin
        next_rdata[sstf_pkg::ST_SYNC_EVT] = sync_evt_flag;
        next_rdata[sstf_pkg::ST_HOLD_EMPTY] = !holding_full;
        next_rdata[sstf_pkg::ST_BUSY] = state != sstf_pkg::SSTF_IDLE;
        next_rdata[sstf_pkg::ST_RX_READY] = rx_ready;
        next_rdata[sstf_pkg::ST_CMP_MATCH] = rx_sync_match;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data stands one cycle after the read strobe only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end
endmodule

`default_nettype wire

// File: sstf_tx_monitor.sv
`default_nettype none

module sstf_tx_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_data_pin_o,
  input wire logic tx_data_pin_oe,
  input wire logic tx_frame_sync_pin_o,
  input wire logic tx_frame_sync_pin_oe,
  input wire logic tx_sync_event,
  input wire logic [1:0] dma_size
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // shadow of software settings
  // ----------------------------------------
  logic fm_wr;
  logic [2:0] shape;
  logic [3:0] fsl;
  logic edge_sel;
  logic multi;
  logic [7:0] hi_cnt;
  logic [7:0] exp_hi;
  assign fm_wr = reg_wr && reg_addr == sstf_pkg::OFS_FRAME_MODE;
  assign exp_hi = ({4'h0, fsl} + 8'h01) * 8'h08; // link period is 8 clocks
  // frame mode and control copies
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shape <= 3'h0;
      fsl <= 4'h0;
      edge_sel <= 1'b0;
      multi <= 1'b0;
    end else begin
      if (fm_wr) begin
        shape <= reg_wdata[22:20];
        fsl <= reg_wdata[19:16];
        edge_sel <= reg_wdata[24];
      end
      if (reg_wr && reg_addr == sstf_pkg::OFS_CONTROL) begin
        multi <= reg_wdata[1];
      end
    end
  end
  // cycles the frame sync output has been high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= tx_frame_sync_pin_o ? hi_cnt + 8'h01 : 8'h00;
    end
  end

  property p_dma_byte;
    fm_wr && reg_wdata[4:0] != 5'h00 && reg_wdata[4:0] <= 5'h07 ##1 !fm_wr
      |-> ##[0:1] dma_size == sstf_pkg::DMA_BYTE;
  endproperty
  a_dma_byte: assert property (p_dma_byte) else $error("dma size not byte");
  property p_dma_half;
    fm_wr && reg_wdata[4:3] == 2'h1 ##1 !fm_wr |-> ##[0:1] dma_size == sstf_pkg::DMA_HALF;
  endproperty
  a_dma_half: assert property (p_dma_half) else $error("dma size not half");
  property p_dma_word;
    fm_wr && reg_wdata[4] ##1 !fm_wr |-> ##[0:1] dma_size == sstf_pkg::DMA_WORD;
  endproperty
  a_dma_word: assert property (p_dma_word) else $error("dma size not word");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_thr_rd;
    reg_rd && reg_addr == sstf_pkg::OFS_TX_HOLD |=> reg_rdata == 32'h0;
  endproperty
  a_thr_rd: assert property (p_thr_rd) else $error("write only register readable");
  property p_fs_oe;
    shape == $past(shape) && shape == $past(shape, 2)
      |-> tx_frame_sync_pin_oe == (shape inside {[3'h1:3'h5]});
  endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("frame sync enable wrong");
  property p_multi;
    multi && $past(multi, 2) && tx_data_pin_oe |-> tx_data_pin_o;
  endproperty
  a_multi: assert property (p_multi) else $error("multi drive drives low");
  property p_pulse;
    $fell(tx_frame_sync_pin_o) && shape == sstf_pkg::FS_POS_PULSE
      |-> hi_cnt + 8'h01 >= exp_hi && hi_cnt <= exp_hi + 8'h01;
  endproperty
  a_pulse: assert property (p_pulse) else $error("frame sync pulse length wrong");
  property p_sync_evt;
    $rose(tx_frame_sync_pin_o) && shape == sstf_pkg::FS_POS_PULSE && !edge_sel
      |-> ##[1:8] tx_sync_event;
  endproperty
  a_sync_evt: assert property (p_sync_evt) else $error("no sync event on rise");
  c_pulse: cover property ($fell(tx_frame_sync_pin_o) && shape == sstf_pkg::FS_POS_PULSE);
  c_multi: cover property (multi && tx_data_pin_oe);
  c_thr: cover property (reg_rd && reg_addr == sstf_pkg::OFS_TX_HOLD);
endmodule

bind sstf_tx sstf_tx_checker i_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .tx_data_pin_o(tx_data_pin_o),
  .tx_data_pin_oe(tx_data_pin_oe),
  .tx_frame_sync_pin_o(tx_frame_sync_pin_o),
  .tx_frame_sync_pin_oe(tx_frame_sync_pin_oe),
  .tx_sync_event(tx_sync_event),
  .dma_size(dma_size)
);

`default_nettype wire

// File: testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, reg_wr, reg_rd, tx_clk_pin, tx_start, d_o, d_oe, fs_o, fs_oe;
  logic sync_evt, dma_req, rx_word_valid, rx_sync_load, cmp_sel, match, run;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx_word;
  logic [1:0] dma_size;
  logic [15:0] rx_sync_bits, cmp_one, cmp_zero;
  logic [3:0] rx_sync_length;
  wire logic d_line = d_oe ? d_o : 1'b0; // pull-down on both lines
  wire logic fs_line = fs_oe ? fs_o : 1'b0;
  int err_total, compares, cycles;
  logic [4:0] dma_len_tab[6] = '{5'h01, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h1f};
  logic [1:0] dma_exp_tab[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

  sstf_tx i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_clk_pin(tx_clk_pin), .tx_start(tx_start), .tx_data_pin_o(d_o),
    .tx_data_pin_oe(d_oe), .tx_frame_sync_pin_i(fs_line), .tx_frame_sync_pin_o(fs_o),
    .tx_frame_sync_pin_oe(fs_oe), .tx_sync_event(sync_evt), .dma_size(dma_size),
    .dma_req(dma_req), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_sync_load(rx_sync_load), .rx_sync_bits(rx_sync_bits),
    .rx_sync_length(rx_sync_length), .compare_select_one(cmp_sel),
    .compare_pattern_one(cmp_one), .compare_pattern_zero(cmp_zero), .rx_sync_match(match));
  sstf_codec i_codec (.run(run), .data_line(d_line), .sync_line(fs_line), .link_clk(tx_clk_pin));

  // ----------------------------------------
  // clock, timeout, checking and bus tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    check("register read", reg_rdata, exp);
  endtask
  // one frame: program, start, then compare what the codec saw
  task automatic frame(input logic [31:0] m, input logic [15:0] s, input logic [31:0] w0,
                       input logic [31:0] w1, input logic [31:0] ctl);
    logic q[$];
    logic [31:0] w;
    int len, fsl, nsync, st;
    logic act;
    len = m[4:0];
    fsl = m[19:16];
    act = (m[22:20] == sstf_pkg::FS_POS_PULSE);
    wr(sstf_pkg::OFS_CONTROL, 32'h0);
    wr(sstf_pkg::OFS_FRAME_MODE, m);
    wr(sstf_pkg::OFS_TX_SYNC, {16'h0, s});
    wr(sstf_pkg::OFS_TX_HOLD, w0);
    wr(sstf_pkg::OFS_CONTROL, ctl);
    i_codec.bq.delete();
    i_codec.fq.delete();
    run <= 1'b1;
    repeat (24) @(posedge clk_sys);
    tx_start <= 1'b1;
    @(posedge clk_sys);
    tx_start <= 1'b0;
    for (int k = 0; k < 400 && dma_req !== 1'b1; k++) @(posedge clk_sys);
    check("dma request", dma_req, 1'b1);
    if (m[11:8] != 4'h0) wr(sstf_pkg::OFS_TX_HOLD, w1);
    repeat (320) @(posedge clk_sys);
    run <= 1'b0;
    repeat (30) @(posedge clk_sys);
    nsync = (m[22:20] inside {3'h1, 3'h2} || m[23]) ? fsl + 1 : 0;
    for (int i = 0; i < nsync; i++) q.push_back(m[23] ? s[m[7] ? fsl - i : i] : m[5]);
    for (int k = 0; k <= m[11:8]; k++) begin
      w = (k == 0) ? w0 : w1;
      for (int i = 0; i <= len; i++) q.push_back(w[m[7] ? len - i : i]);
    end
    q.push_back(m[5]);
    q.push_back(m[5]);
    st = 0;
    while (st < i_codec.fq.size() && i_codec.fq[st] !== act) st++;
    check("idle before frame", i_codec.bq[st - 1], m[5]);
    for (int i = 0; i < q.size(); i++) begin
      check("data bit", i_codec.bq[st + i], q[i]);
      check("sync bit", i_codec.fq[st + i], (i < nsync) ? act : !act);
    end
    check("sync event pin", sync_evt, 1'b1);
    // event and holding empty set, busy clear once the frame is over
    rd_chk(sstf_pkg::OFS_STATUS, 32'h3);
    rd_chk(sstf_pkg::OFS_STATUS, 32'h2);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, tx_start, rx_word_valid, rx_sync_load, cmp_sel, run} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rx_word = 32'h0;
    rx_sync_bits = 16'h0;
    rx_sync_length = 4'h0;
    cmp_one = 16'h0;
    err_total = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(sstf_pkg::OFS_FRAME_MODE, sstf_pkg::FRAME_MODE_RESET);
    wr(sstf_pkg::OFS_FRAME_MODE, 32'hffffffff);
    rd_chk(sstf_pkg::OFS_FRAME_MODE, sstf_pkg::FRAME_MODE_MASK);
    wr(sstf_pkg::OFS_TX_SYNC, 32'hffffffff);
    rd_chk(sstf_pkg::OFS_TX_SYNC, 32'h0000ffff);
    wr(sstf_pkg::OFS_CMP_ZERO, 32'h1234abcd);
    rd_chk(sstf_pkg::OFS_CMP_ZERO, 32'h0000abcd);
    check("pattern zero port", cmp_zero, 32'habcd);
    rd_chk(sstf_pkg::OFS_TX_HOLD, 32'h0);
    wr(8'h40, 32'h1);
    rd_chk(8'h40, 32'h0);
    rx_word <= 32'h89abcdef;
    rx_word_valid <= 1'b1;
    @(posedge clk_sys);
    rx_word_valid <= 1'b0;
    rd_chk(sstf_pkg::OFS_RX_HOLD, 32'h89abcdef);
    wr(sstf_pkg::OFS_CMP_ZERO, 32'h0000000d);
    for (int j = 0; j < 2; j++) begin
      cmp_sel <= j[0];
      cmp_one <= 16'h0005;
      rx_sync_bits <= 16'hfffd;
      rx_sync_length <= 4'h3;
      rx_sync_load <= 1'b1;
      @(posedge clk_sys);
      rx_sync_load <= 1'b0;
      rd_chk(sstf_pkg::OFS_RX_SYNC, 32'h0000000d);
      check("compare match", match, (j == 0));
    end
    foreach (dma_len_tab[i]) begin
      wr(sstf_pkg::OFS_FRAME_MODE, {27'h0, dma_len_tab[i]});
      @(posedge clk_sys); // dma size is registered from the new field
      check("dma size", dma_size, dma_exp_tab[i]);
    end
    frame(32'h00a30127, 16'h000a, 32'h000000a5, 32'h0000003c, 32'h1);
    frame(32'h01110089, 16'h0000, 32'h000002c5, 32'h0, 32'h3);
    conclude();
  end
endmodule

`default_nettype wire
